// ---- pkg/frp_pkg.sv ----
// Constants, types and helpers shared by the FIFO read-port block
package frp_pkg;

	localparam int DATA_W = 40;
	localparam int ADDR_W = 14;
	localparam int PTR_W  = 15;
	localparam int BUF_W  = 2 * DATA_W + 1;
	localparam int BUF_DEPTH = 2;

	localparam logic [PTR_W-1:0]  DEPTH_WORDS = 15'h4000;
	localparam logic [PTR_W-1:0]  PTR_RESET   = 15'h0000;
	localparam logic [1:0]        SUB_RESET   = 2'h0;
	localparam logic [DATA_W-1:0] DATA_RESET  = 40'h00_0000_0000;

	// Default flag offsets picked by the flag-select pins at master reset
	localparam logic [PTR_W-1:0] FLAG_DEF_OFF0 = 15'h0007;
	localparam logic [PTR_W-1:0] FLAG_DEF_OFF1 = 15'h003F;
	localparam logic [PTR_W-1:0] FLAG_DEF_OFF2 = 15'h007F;
	localparam logic [PTR_W-1:0] FLAG_DEF_OFF3 = 15'h03FF;

	typedef enum logic [1:0]
	{
		FRP_W40 = 2'h0,
		FRP_W20 = 2'h1,
		FRP_W10 = 2'h2
	} frp_width_t;

	// Units per word as a shift: x40 one, x20 two, x10 four
	function automatic logic [1:0] frp_unit_shift(input frp_width_t w);
		unique case (w)
			FRP_W40: frp_unit_shift = 2'h0;
			FRP_W20: frp_unit_shift = 2'h1;
			FRP_W10: frp_unit_shift = 2'h2;
			default: frp_unit_shift = 2'h0;
		endcase
	endfunction : frp_unit_shift

	function automatic logic [PTR_W-1:0] frp_def_offset(input logic [1:0] sel);
		unique case (sel)
			2'h0: frp_def_offset = FLAG_DEF_OFF0;
			2'h1: frp_def_offset = FLAG_DEF_OFF1;
			2'h2: frp_def_offset = FLAG_DEF_OFF2;
			2'h3: frp_def_offset = FLAG_DEF_OFF3;
		endcase
	endfunction : frp_def_offset

endpackage : frp_pkg

// ---- logic/frp_mem.sv ----
// Word store with one write port and two asynchronous read ports
`timescale 1ns/1ps
module frp_mem
	import frp_pkg::*;
(
	// Clock
	input  wire logic              clk,
	input  wire logic              ce,
	// Write port
	input  wire logic              wrEn,
	input  wire logic [ADDR_W-1:0] wrAddr,
	input  wire logic [DATA_W-1:0] wrData,
	// Read ports
	input  wire logic [ADDR_W-1:0] rdAddrA,
	input  wire logic [ADDR_W-1:0] rdAddrB,
	output logic      [DATA_W-1:0] rdDataA,
	output logic      [DATA_W-1:0] rdDataB
);

	logic [DATA_W-1:0] store [2**ADDR_W];

	// No reset on the array: contents are only valid behind the write pointer
	always_ff @(posedge clk)
	begin
		if (ce && wrEn)
			store[wrAddr] <= wrData;
	end

	assign rdDataA = store[rdAddrA];
	assign rdDataB = store[rdAddrB];

endmodule : frp_mem

// ---- logic/frp_skid.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module frp_skid
	import frp_pkg::*;
#(
	parameter int WIDTH = BUF_W
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic             flush,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	logic [WIDTH-1:0] slot_q [BUF_DEPTH];
	logic             wrIdx_q;
	logic             rdIdx_q;
	logic [1:0]       fill_q;
	logic             push;
	logic             pull;

	assign inReady  = (fill_q != 2'h2);
	assign outValid = (fill_q != 2'h0);
	assign outData  = slot_q[rdIdx_q];
	assign push     = inValid && inReady;
	assign pull     = outValid && outReady;

	always_ff @(posedge clk)
	begin
		if (ce && push)
			slot_q[wrIdx_q] <= inData;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wrIdx_q <= 1'b0;
			rdIdx_q <= 1'b0;
			fill_q  <= 2'h0;
		end
		else if (ce)
		begin
			if (flush)
			begin
				wrIdx_q <= 1'b0;
				rdIdx_q <= 1'b0;
				fill_q  <= 2'h0;
			end
			else
			begin
				if (push)
					wrIdx_q <= !wrIdx_q;
				if (pull)
					rdIdx_q <= !rdIdx_q;
				fill_q <= fill_q + {1'b0, push} - {1'b0, pull};
			end
		end
	end

endmodule : frp_skid

// ---- logic/frp_read_port.sv ----
// Read port of a FIFO: width matching, data rate, flags, resets and replay
`timescale 1ns/1ps
module frp_read_port
	import frp_pkg::*;
(
	// Clock, reset and enable
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              ce,
	// Device resets, sampled on clk
	input  wire logic              fullResetN,
	input  wire logic              pointerResetN,
	// Configuration pins
	input  wire logic              widthMatchSel,
	input  wire logic              inputWidthSel,
	input  wire logic              outputWidthSel,
	input  wire logic              fallThroughSel,
	input  wire logic              readRateSel,
	input  wire logic [1:0]        flagSel,
	// Write side
	input  wire logic              wrEn,
	input  wire logic [ADDR_W-1:0] wrAddr,
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic [PTR_W-1:0]  wrPtr,
	input  wire logic [PTR_W-1:0]  emptyOffset,
	input  wire logic [PTR_W-1:0]  fullOffset,
	input  wire logic              offsetLoaded,
	output frp_width_t             cfgInWidth,
	// Read controls
	input  wire logic              readEnableN,
	input  wire logic              readSelectN,
	input  wire logic              outEnableN,
	input  wire logic              replayReqN,
	input  wire logic              readMark,
	input  wire logic              outReady,
	// Read data and flags
	output logic      [DATA_W-1:0] readDataOut,
	output logic      [DATA_W-1:0] readDataFall,
	output logic                   readDataValid,
	output logic                   readDataOe,
	output logic                   emptyN,
	output logic                   nearEmptyN,
	output logic                   nearFullN
);

	frp_width_t        outWidth_q;
	logic              fallThrough_q;
	logic              ddr_q;
	logic [1:0]        flagSel_q;
	logic [PTR_W-1:0]  rdPtr_q;
	logic [1:0]        sub_q;
	logic [PTR_W-1:0]  markPtr_q;
	logic              markValid_q;
	logic              readSelN_q;
	logic              inReset;
	logic              portEn;
	logic              replay;
	logic              markNow;
	logic              ftMode;
	logic [PTR_W-1:0]  count;
	logic [PTR_W-1:0]  free;
	logic [16:0]       availUnits;
	logic [PTR_W-1:0]  effEmptyOff;
	logic [PTR_W-1:0]  effFullOff;
	logic [DATA_W-1:0] memA;
	logic [DATA_W-1:0] memB;
	logic [16:0]       pos1;
	logic [16:0]       pos2;
	logic [DATA_W-1:0] unit0;
	logic [DATA_W-1:0] unit1;
	logic              twoUnits;
	logic              srcValid;
	logic              srcReady;
	logic [BUF_W-1:0]  srcData;
	logic              pop;
	logic              bufValid;
	logic              sinkReady;
	logic [BUF_W-1:0]  bufData;
	logic              takeOut;
	logic              load;

	// Pick one output unit out of a stored word, zero above its width
	function automatic logic [DATA_W-1:0] unitOf(input logic [DATA_W-1:0] w,
		input logic [1:0] s, input frp_width_t ow);
		unique case (ow)
			FRP_W40: unitOf = w;
			FRP_W20: unitOf = s[0] ? {20'h0_0000, w[39:20]} : {20'h0_0000, w[19:0]};
			FRP_W10: unitOf = {30'h0000_0000, w[10*s +: 10]};
			default: unitOf = w;
		endcase
	endfunction : unitOf

	// Next read position, word pointer above unit index
	function automatic logic [16:0] advance(input logic [PTR_W-1:0] p,
		input logic [1:0] s, input frp_width_t ow);
		logic lastUnit;
		lastUnit = (ow == FRP_W40) || (ow == FRP_W20 && s == 2'h1) || (s == 2'h3);
		advance = lastUnit ? {p + 15'h0001, 2'h0} : {p, s + 2'h1};
	endfunction : advance

	assign inReset = !fullResetN || !pointerResetN;
	assign portEn  = !readSelN_q && !inReset;
	assign replay  = !replayReqN && !inReset;
	assign markNow = readMark && !inReset;
	assign ftMode  = fallThrough_q && !ddr_q;

	// Configuration is caught only while master reset is held
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			outWidth_q    <= FRP_W40;
			cfgInWidth    <= FRP_W40;
			fallThrough_q <= 1'b0;
			ddr_q         <= 1'b0;
			flagSel_q     <= 2'h0;
		end
		else if (ce && !fullResetN)
		begin
			fallThrough_q <= fallThroughSel;
			ddr_q         <= readRateSel;
			flagSel_q     <= flagSel;
			if (!widthMatchSel)
			begin
				cfgInWidth <= FRP_W40;
				outWidth_q <= FRP_W40;
			end
			else
			begin
				cfgInWidth <= !inputWidthSel ? FRP_W40 : (outputWidthSel ? FRP_W10 : FRP_W20);
				outWidth_q <= inputWidthSel ? FRP_W40 : (outputWidthSel ? FRP_W10 : FRP_W20);
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			readSelN_q <= 1'b1;
		else if (ce)
			readSelN_q <= readSelectN;
	end

	assign count       = wrPtr - rdPtr_q;
	assign free        = DEPTH_WORDS - count;
	assign availUnits  = ({2'h0, count} << frp_unit_shift(outWidth_q)) - {15'h0000, sub_q};
	assign effEmptyOff = offsetLoaded ? emptyOffset : frp_def_offset(flagSel_q);
	assign effFullOff  = offsetLoaded ? fullOffset : frp_def_offset(flagSel_q);

	frp_mem i_frp_mem
	(
		.clk     (clk),
		.ce      (ce),
		.wrEn    (wrEn),
		.wrAddr  (wrAddr),
		.wrData  (wrData),
		.rdAddrA (rdPtr_q[ADDR_W-1:0]),
		.rdAddrB (rdPtr_q[ADDR_W-1:0] + 14'h0001),
		.rdDataA (memA),
		.rdDataB (memB)
	);

	assign pos1     = advance(rdPtr_q, sub_q, outWidth_q);
	assign pos2     = advance(pos1[16:2], pos1[1:0], outWidth_q);
	assign unit0    = unitOf(memA, sub_q, outWidth_q);
	assign unit1    = unitOf((pos1[16:2] == rdPtr_q) ? memA : memB, pos1[1:0], outWidth_q);
	assign twoUnits = ddr_q && (availUnits > 17'h0_0001);
	// Standard mode fetches on request; fall-through prefetches on its own, at single rate only
	assign srcValid = portEn && (ftMode || !readEnableN) && (availUnits != 17'h0_0000)
		&& !replay;
	assign srcData  = {twoUnits, unit1, unit0};
	assign pop      = srcValid && srcReady;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdPtr_q <= PTR_RESET;
			sub_q   <= SUB_RESET;
		end
		else if (ce)
		begin
			if (inReset)
			begin
				rdPtr_q <= PTR_RESET;
				sub_q   <= SUB_RESET;
			end
			else if (replay)
			begin
				rdPtr_q <= markValid_q ? markPtr_q : PTR_RESET;
				sub_q   <= SUB_RESET;
			end
			else if (pop)
			begin
				rdPtr_q <= twoUnits ? pos2[16:2] : pos1[16:2];
				sub_q   <= twoUnits ? pos2[1:0] : pos1[1:0];
			end
		end
	end

	// Only the last mark is kept; a reset forgets it
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			markPtr_q   <= PTR_RESET;
			markValid_q <= 1'b0;
		end
		else if (ce)
		begin
			if (inReset)
				markValid_q <= 1'b0;
			else if (markNow)
			begin
				markPtr_q   <= rdPtr_q;
				markValid_q <= 1'b1;
			end
		end
	end

	// The buffer absorbs a stalled receiver without dropping a fetched unit
	frp_skid #(.WIDTH(BUF_W)) i_frp_skid
	(
		.clk      (clk),
		.nrst     (nrst),
		.ce       (ce),
		.flush    (inReset || replay),
		.inValid  (srcValid),
		.inReady  (srcReady),
		.inData   (srcData),
		.outValid (bufValid),
		.outReady (sinkReady),
		.outData  (bufData)
	);

	assign takeOut   = portEn && !readEnableN;
	assign sinkReady = outReady && !inReset && (!ftMode || !readDataValid || takeOut);
	assign load      = bufValid && sinkReady;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			readDataOut   <= DATA_RESET;
			readDataFall  <= DATA_RESET;
			readDataValid <= 1'b0;
		end
		else if (ce)
		begin
			if (inReset)
			begin
				readDataOut   <= DATA_RESET;
				readDataFall  <= DATA_RESET;
				readDataValid <= 1'b0;
			end
			else if (replay)
				readDataValid <= 1'b0;
			else if (load)
			begin
				readDataOut   <= bufData[DATA_W-1:0];
				readDataFall  <= bufData[BUF_W-1] ? bufData[2*DATA_W-1:DATA_W] : DATA_RESET;
				readDataValid <= 1'b1;
			end
			else if (ftMode && takeOut)
				readDataValid <= 1'b0;
		end
	end

	// Output enable wins; read select only matters outside reset
	assign readDataOe = !outEnableN && (inReset || !readSelN_q);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			emptyN     <= 1'b0;
			nearEmptyN <= 1'b0;
			nearFullN  <= 1'b1;
		end
		else if (ce)
		begin
			if (inReset || replay)
				emptyN <= ftMode;
			else
				emptyN <= ftMode ? !readDataValid : (availUnits != 17'h0_0000);
			nearEmptyN <= !inReset && (count >= effEmptyOff);
			nearFullN  <= inReset || (free > effFullOff);
		end
	end

	property p_mark;
		@(posedge clk) disable iff (!nrst)
		ce && markNow |=> markPtr_q == $past(rdPtr_q) && markValid_q;
	endproperty
	a_mark: assert property (p_mark) else $error("mark not recorded");

	property p_replay;
		@(posedge clk) disable iff (!nrst)
		ce && replay && !markValid_q |=> rdPtr_q == PTR_RESET && sub_q == SUB_RESET;
	endproperty
	a_replay: assert property (p_replay) else $error("replay missed first word");

	property p_replayMark;
		@(posedge clk) disable iff (!nrst)
		ce && replay && markValid_q |=> rdPtr_q == $past(markPtr_q);
	endproperty
	a_replayMark: assert property (p_replayMark) else $error("replay missed mark");

	property p_replayFlag;
		@(posedge clk) disable iff (!nrst)
		ce && replay |=> emptyN == ftMode && !readDataValid;
	endproperty
	a_replayFlag: assert property (p_replayFlag) else $error("replay flag wrong");

	property p_nearEmpty;
		@(posedge clk) disable iff (!nrst)
		ce && fullResetN && pointerResetN |=> nearEmptyN == ($past(count) >= $past(effEmptyOff));
	endproperty
	a_nearEmpty: assert property (p_nearEmpty) else $error("near empty wrong");

	property p_nearFull;
		@(posedge clk) disable iff (!nrst)
		ce && fullResetN && pointerResetN |=> nearFullN == ($past(free) > $past(effFullOff));
	endproperty
	a_nearFull: assert property (p_nearFull) else $error("near full wrong");

	property p_outEnable;
		@(posedge clk) disable iff (!nrst)
		outEnableN |-> !readDataOe;
	endproperty
	a_outEnable: assert property (p_outEnable) else $error("data driven while disabled");

	property p_resetDrive;
		@(posedge clk) disable iff (!nrst)
		inReset && !outEnableN |-> readDataOe;
	endproperty
	a_resetDrive: assert property (p_resetDrive) else $error("reset drive wrong");

	property p_fullReset;
		@(posedge clk) disable iff (!nrst)
		ce && !fullResetN |=> rdPtr_q == PTR_RESET && readDataOut == DATA_RESET;
	endproperty
	a_fullReset: assert property (p_fullReset) else $error("reset left state");

	property p_cfgHold;
		@(posedge clk) disable iff (!nrst)
		fullResetN && !pointerResetN |=> $stable(outWidth_q) && $stable(fallThrough_q);
	endproperty
	a_cfgHold: assert property (p_cfgHold) else $error("partial reset changed mode");

	property p_emptyRead;
		@(posedge clk) disable iff (!nrst)
		ce && availUnits == 17'h0_0000 && !inReset && !replay |=> $stable(rdPtr_q);
	endproperty
	a_emptyRead: assert property (p_emptyRead) else $error("read while empty moved");

	property p_sdrSingle;
		@(posedge clk) disable iff (!nrst)
		!ddr_q |-> readDataFall == DATA_RESET;
	endproperty
	a_sdrSingle: assert property (p_sdrSingle) else $error("two units in single rate");

endmodule : frp_read_port

// ---- sim/frp_reader.sv ----
// Downstream reader model on the data side of the FIFO read port
`timescale 1ns/1ps
module frp_reader
	import frp_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// Bench control
	input  wire logic              stall,
	input  wire frp_width_t        outWidth,
	// Read data
	input  wire logic              readDataValid,
	input  wire logic [DATA_W-1:0] readDataOut,
	output logic                   outReady,
	output logic      [DATA_W-1:0] lastUnit
);
	logic [DATA_W-1:0] mask;

	// Stalls on command only, to fill the buffer behind it
	assign outReady = !stall;
	// Upper bits of a narrow bus are never looked at
	assign mask = (outWidth == FRP_W40) ? 40'hFF_FFFF_FFFF :
		(outWidth == FRP_W20) ? 40'h00_000F_FFFF : 40'h00_0000_03FF;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			lastUnit <= 40'h00_0000_0000;
		else if (readDataValid && outReady)
			lastUnit <= readDataOut & mask;
	end
endmodule : frp_reader

// ---- sim/tb_top.sv ----
// Self-checking bench for the FIFO read port
`timescale 1ns/1ps
module tb_top
	import frp_pkg::*;
;
	logic              clk, nrst, ce, fullResetN, pointerResetN;
	logic              widthMatchSel, inputWidthSel, outputWidthSel;
	logic              fallThroughSel, readRateSel, wrEn, offsetLoaded;
	logic [1:0]        flagSel;
	logic [ADDR_W-1:0] wrAddr;
	logic [DATA_W-1:0] wrData, readDataOut, readDataFall, lastUnit;
	logic [PTR_W-1:0]  wrPtr, emptyOffset, fullOffset;
	logic              readEnableN, readSelectN, outEnableN, replayReqN;
	logic              readMark, outReady, stall, readDataValid, readDataOe;
	logic              emptyN, nearEmptyN, nearFullN;
	frp_width_t        cfgInWidth, outWidth;
	int                errors, tests_run, cyc;

	frp_read_port i_frp_read_port (.clk, .nrst, .ce, .fullResetN, .pointerResetN,
		.widthMatchSel, .inputWidthSel, .outputWidthSel, .fallThroughSel, .readRateSel,
		.flagSel, .wrEn, .wrAddr, .wrData, .wrPtr, .emptyOffset, .fullOffset,
		.offsetLoaded, .cfgInWidth, .readEnableN, .readSelectN, .outEnableN,
		.replayReqN, .readMark, .outReady, .readDataOut, .readDataFall,
		.readDataValid, .readDataOe, .emptyN, .nearEmptyN, .nearFullN);

	frp_reader i_frp_reader (.clk, .nrst, .stall, .outWidth, .readDataValid,
		.readDataOut, .outReady, .lastUnit);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = !clk;
	end

	function automatic logic [DATA_W-1:0] dat(input int i);
		dat = 40'h12_3456_789A + 40'(i);
	endfunction : dat

	task automatic give_verdict();
		$display("counts: errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			$display("BAD %0t run did not finish", $time);
			give_verdict();
		end
	end

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
		input string m);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t %s: got %h want %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic full_reset(input logic bm, iw, ow, ft, rr, input logic [1:0] fs);
		@(negedge clk);
		{widthMatchSel, inputWidthSel, outputWidthSel} = {bm, iw, ow};
		{fallThroughSel, readRateSel, flagSel} = {ft, rr, fs};
		fullResetN = 1'b0;
		readSelectN = 1'b1;
		wrPtr = PTR_RESET;
		repeat (3) @(negedge clk);
		chk(readDataOe, 1'b1, "select ignored in reset");
		chk(readDataOut, DATA_RESET, "data cleared by reset");
		fullResetN = 1'b1;
		readSelectN = 1'b0;
		@(negedge clk);
	endtask : full_reset

	task automatic wr(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk);
			wrEn = 1'b1;
			wrAddr = ADDR_W'(i);
			wrData = dat(i);
		end
		@(negedge clk);
		wrEn = 1'b0;
		wrPtr = PTR_W'(n);
	endtask : wr

	task automatic pulse(ref logic s, input logic act);
		@(negedge clk);
		s = act;
		@(negedge clk);
		s = !act;
	endtask : pulse

	// Output latency goes through the buffer, so allow a few cycles
	task automatic wt(input logic [DATA_W-1:0] exp, input string m);
		int k;
		k = 0;
		while (readDataOut !== exp && k < 8)
		begin
			@(negedge clk);
			k++;
		end
		chk(readDataOut, exp, m);
	endtask : wt

	task automatic rd(input logic [DATA_W-1:0] exp, input string m);
		pulse(readEnableN, 1'b0);
		wt(exp, m);
	endtask : rd

	// The empty indication may show at either of the two edges after the request
	task automatic replay();
		logic e;
		pulse(replayReqN, 1'b0);
		e = emptyN;
		@(negedge clk);
		chk((e === 1'b0 || emptyN === 1'b0) ? 1'b0 : 1'b1, 1'b0, "empty on replay");
	endtask : replay

	initial
	begin
		{nrst, fullResetN, wrEn, readMark, stall, offsetLoaded, ce} = 7'h01;
		{pointerResetN, readEnableN, readSelectN, replayReqN} = 4'hF;
		{widthMatchSel, inputWidthSel, outputWidthSel, fallThroughSel} = 4'h0;
		{readRateSel, outEnableN, flagSel} = 4'h0;
		{wrAddr, wrData, wrPtr} = '0;
		{emptyOffset, fullOffset} = {15'h0007, 15'h3FF8};
		outWidth = FRP_W40;
		{errors, tests_run, cyc} = '0;
		repeat (10) @(negedge clk);
		nrst = 1'b1;

		full_reset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
		chk(emptyN, 1'b0, "empty after reset");
		chk(cfgInWidth, FRP_W40, "input width");
		wr(6);
		repeat (2) @(negedge clk);
		chk(nearEmptyN, 1'b0, "count below offset");
		chk(emptyN, 1'b1, "words visible");
		wr(7);
		repeat (2) @(negedge clk);
		chk(nearEmptyN, 1'b1, "count at offset");
		offsetLoaded = 1'b1;
		repeat (2) @(negedge clk);
		chk(nearFullN, 1'b1, "free above offset");
		wr(8);
		repeat (2) @(negedge clk);
		chk(nearFullN, 1'b0, "free at offset");
		offsetLoaded = 1'b0;
		$display("test flags done");

		rd(dat(0), "read 0");
		rd(dat(1), "read 1");
		pulse(readMark, 1'b1);
		rd(dat(2), "read 2");
		rd(dat(3), "read 3");
		replay();
		rd(dat(2), "replay to mark");
		rd(dat(3), "read 3 again");
		rd(dat(4), "read 4");
		pulse(readMark, 1'b1);
		rd(dat(5), "read 5");
		replay();
		rd(dat(5), "latest mark");
		rd(dat(6), "read 6");
		rd(dat(7), "read 7");
		pulse(readEnableN, 1'b0);
		repeat (2) @(negedge clk);
		chk(readDataOut, dat(7), "read while empty");
		chk(emptyN, 1'b0, "empty after last");
		$display("test replay done");

		@(negedge clk);
		outEnableN = 1'b1;
		@(negedge clk);
		chk(readDataOe, 1'b0, "outputs floated");
		chk(nearFullN, 1'b1, "flags not floated");
		outEnableN = 1'b0;
		readSelectN = 1'b1;
		repeat (2) @(negedge clk);
		chk(readDataOe, 1'b0, "deselected");
		readSelectN = 1'b0;
		repeat (2) @(negedge clk);
		chk(readDataOe, 1'b1, "selected");
		$display("test drive done");

		flagSel = 2'h3;
		pointerResetN = 1'b0;
		wrPtr = PTR_RESET;
		repeat (2) @(negedge clk);
		chk(readDataOut, DATA_RESET, "partial reset data");
		pointerResetN = 1'b1;
		wr(7);
		repeat (2) @(negedge clk);
		chk(nearEmptyN, 1'b1, "offset kept");
		ce = 1'b0;
		pulse(readEnableN, 1'b0);
		repeat (2) @(negedge clk);
		chk(readDataOut, DATA_RESET, "frozen by clock enable");
		ce = 1'b1;
		rd(dat(0), "pointer zeroed");
		replay();
		rd(dat(0), "replay to start");
		$display("test partial reset done");

		full_reset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
		wr(5);
		stall = 1'b1;
		repeat (3) pulse(readEnableN, 1'b0);
		chk(readDataOut, DATA_RESET, "held while stalled");
		stall = 1'b0;
		wt(dat(1), "buffer drained");
		rd(dat(2), "no word lost");
		$display("test stall done");

		for (int k = 0; k < 2; k++)
		begin
			full_reset(1'b1, 1'b0, k[0], 1'b0, 1'b0, 2'h0);
			outWidth = k ? FRP_W10 : FRP_W20;
			chk(cfgInWidth, FRP_W40, "wide input");
			wr(1);
			for (int u = 0; u < (k ? 4 : 2); u++)
				rd(k ? (dat(0) >> (u * 10)) & 40'h00_0000_03FF
					: (dat(0) >> (u * 20)) & 40'h00_000F_FFFF, "unit");
		end
		@(negedge clk);
		chk(lastUnit, dat(0) >> 30, "reader got last unit");
		for (int k = 0; k < 2; k++)
		begin
			full_reset(1'b1, 1'b1, !k[0], 1'b0, 1'b0, 2'h0);
			chk(cfgInWidth, k ? FRP_W20 : FRP_W10, "narrow input");
		end
		$display("test widths done");

		full_reset(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0);
		outWidth = FRP_W40;
		wr(2);
		rd(dat(0), "double rate first");
		chk(readDataFall, dat(1), "double rate second");
		full_reset(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0);
		chk(emptyN, 1'b1, "fall-through not ready");
		wr(1);
		wt(dat(0), "first word falls through");
		chk(readDataValid, 1'b1, "fall-through word valid");
		@(negedge clk);
		chk(emptyN, 1'b0, "output ready after fall-through");
		$display("test rate and timing done");
		give_verdict();
	end
endmodule : tb_top
